// File: common/dsp_arith_pkg.sv
package dsp_arith_pkg;

  // Data widths of the datapath.
  localparam int WORD_W = 16;
  localparam int ACC_W = 40;

  // Divide iteration count requested by the controller's repeat loop.
  localparam logic [5:0] DIV_STEPS = 6'h12;
  localparam logic [5:0] DIV_LAST_COUNT = 6'h00;

  // Saturation bounds for the 1.15 write path.
  localparam logic [23:0] SAT_POS_LIMIT = 24'h00_7FFF;
  localparam logic [23:0] SAT_NEG_LIMIT = 24'hFF_8000;
  localparam logic [15:0] SAT_POS_WORD = 16'h7FFF;
  localparam logic [15:0] SAT_NEG_WORD = 16'h8000;

  // Sign bit position of the source accumulator.
  localparam int ACC_SIGN_BIT = 39;

  // Reset values.
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;

  // Shifter input placement for the X bus word.
  localparam int XBUS_RIGHT_POS = 16;
  localparam int XBUS_LEFT_POS = 0;

  typedef enum logic [2:0] {
    OP_FRACTIONAL_DIVIDE = 3'b000,
    OP_SIGNED_LONG_DIVIDE = 3'b001,
    OP_UNSIGNED_LONG_DIVIDE = 3'b010,
    OP_SIGNED_SHORT_DIVIDE = 3'b011,
    OP_UNSIGNED_SHORT_DIVIDE = 3'b100
  } divide_op_e;

  typedef enum logic [1:0] {
    SRC_ACC_A = 2'b00,
    SRC_ACC_B = 2'b01,
    SRC_XBUS = 2'b10
  } shift_src_e;

  typedef enum logic [1:0] {
    DIV_IDLE = 2'b00,
    DIV_RUN = 2'b01,
    DIV_DONE = 2'b10
  } div_state_e;

  // Divide request from the decode logic.
  typedef struct packed {
    logic step;
    divide_op_e op;
    logic [5:0] repeat_counter;
    logic [15:0] dividend_lo;
    logic [15:0] dividend_hi;
    logic [15:0] divisor;
  } div_req_s;

  // Divide answer towards register write-back.
  typedef struct packed {
    logic valid;
    logic [15:0] working_register_zero;
    logic [15:0] working_register_one;
  } div_rsp_s;

  // Shift request.
  typedef struct packed {
    logic valid;
    shift_src_e src;
    logic arithmetic;
    logic signed [5:0] amount;
    logic [39:0] acc_a;
    logic [39:0] acc_b;
    logic [15:0] xbus;
  } shift_req_s;

  // Saturation request.
  typedef struct packed {
    logic valid;
    logic data_write_saturation_enable;
    logic [23:0] rounded;
    logic acc_sign;
    logic acc_overflow;
    logic round_overflow;
  } sat_req_s;

endpackage

// File: verilog/dsp_arith_datapath.sv
//////////////////////////////////////////////////////////////////////////////
// Function
// [RULE_01] The divider performs fractional, signed and unsigned long, and signed and unsigned short divides.
// [RULE_02] Short divides use the long iteration count, with the dividend zero or sign extended at the first step.
// [RULE_03] Each divide step is driven by the repeat counter, which the divider never loads itself.
// [RULE_04] The controller repeats the divide step 18 times, so a whole divide takes 19 cycles.
// [RULE_05] A divide may be interrupted between steps, and the interrupting code saves the context.
// [RULE_06] Long dividends come from a register pair with the upper half in the higher register; quotient goes to register zero, remainder to register one.
// [RULE_07] The write saturation stage takes a rounded 1.15 value with overflow status and never alters the accumulator.
// [RULE_08] With saturation enabled an input above 0x007FFF writes 0x7FFF.
// [RULE_09] With saturation enabled an input below 0xFF8000 writes 0x8000.
// [RULE_10] The operand sign for saturation is taken from accumulator bit 39.
// [RULE_11] With saturation disabled the rounded value passes unchanged.
// [RULE_12] The shifter does right shifts, arithmetic or logical, or left shifts of up to 16 bits in one cycle.
// [RULE_13] The shifter operand comes from either accumulator or the X bus.
// [RULE_14] The signed shift amount shifts right when positive, left when negative, and not at all when zero.
// [RULE_15] The shifter is 40 bits wide and gives a 40-bit and a 16-bit result.
// [RULE_16] An X bus word enters at bits 16 to 31 for right shifts and at bits 0 to 15 for left shifts.
// [RULE_17] Arithmetic right shifts fill with sign copies; logical right and left shifts fill with zeros.
module dsp_arith_datapath
  import dsp_arith_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input div_req_s div_req,
  output div_rsp_s div_rsp,
  output logic div_busy,
  input shift_req_s shift_req,
  output logic [39:0] shift_acc_result,
  output logic [15:0] shift_word_result,
  output logic shift_valid,
  input sat_req_s sat_req,
  output logic [15:0] sat_word,
  output logic sat_valid
);

  //////////////////////////////////////////////////////////////////////////////
  // Divide unit: restoring divider, one quotient bit per repeated step until 16 bits are done.

  div_state_e state_q, state_d;
  logic [31:0] rem_q, rem_d;       // Partial remainder and shifted dividend.
  logic [15:0] quot_q, quot_d;
  logic [15:0] dvsr_q, dvsr_d;
  logic neg_quot_q, neg_quot_d;
  logic neg_rem_q, neg_rem_d;
  logic [4:0] bit_cnt_q, bit_cnt_d;
  div_rsp_s rsp_q, rsp_d;
  logic busy_q, busy_d;

  logic is_signed, is_long, is_frac;
  logic [31:0] dividend_ext;
  logic [31:0] dividend_mag;
  logic [15:0] divisor_mag;
  logic [16:0] trial;
  logic [32:0] shifted;

  // Operand preparation for the first step.
  always_comb begin
    is_signed = (div_req.op == OP_FRACTIONAL_DIVIDE) || (div_req.op == OP_SIGNED_LONG_DIVIDE) ||
                (div_req.op == OP_SIGNED_SHORT_DIVIDE);  // [RULE_01]
    is_long = (div_req.op == OP_SIGNED_LONG_DIVIDE) ||
              (div_req.op == OP_UNSIGNED_LONG_DIVIDE);
    is_frac = (div_req.op == OP_FRACTIONAL_DIVIDE);
    if (is_frac) begin
      // Fractional: dividend is a 1.15 value scaled above the divisor.
      dividend_ext = {div_req.dividend_lo, 16'h0000};  // [RULE_01]
    end else if (is_long) begin
      dividend_ext = {div_req.dividend_hi, div_req.dividend_lo};  // [RULE_06]
    end else if (is_signed) begin
      dividend_ext = {{16{div_req.dividend_lo[15]}}, div_req.dividend_lo};  // [RULE_02]
    end else begin
      dividend_ext = {16'h0000, div_req.dividend_lo};  // [RULE_02]
    end
    if (is_signed && dividend_ext[31]) begin
      dividend_mag = 32'(-dividend_ext);
    end else begin
      dividend_mag = dividend_ext;
    end
    if (is_signed && div_req.divisor[15]) begin
      divisor_mag = 16'(-div_req.divisor);
    end else begin
      divisor_mag = div_req.divisor;
    end
  end

  // Next state of the divider; steps happen only when the controller repeats them.
  always_comb begin
    state_d = state_q;
    rem_d = rem_q;
    quot_d = quot_q;
    dvsr_d = dvsr_q;
    neg_quot_d = neg_quot_q;
    neg_rem_d = neg_rem_q;
    bit_cnt_d = bit_cnt_q;
    rsp_d = rsp_q;
    rsp_d.valid = 1'b0;
    busy_d = busy_q;
    shifted = {rem_q, 1'b0};
    trial = 17'(shifted[32:16]) - {1'b0, dvsr_q};
    case (state_q)
      DIV_IDLE: begin
        // The count is only read, never written here.
        if (div_req.step && div_req.repeat_counter == DIV_STEPS - 6'h01) begin  // [RULE_03]
          rem_d = dividend_mag;
          dvsr_d = divisor_mag;
          quot_d = WORD_RESET;
          neg_quot_d = is_signed && (dividend_ext[31] ^ div_req.divisor[15]);
          neg_rem_d = is_signed && dividend_ext[31];
          bit_cnt_d = 5'h10;
          busy_d = 1'b1;
          state_d = DIV_RUN;
        end
      end
      DIV_RUN: begin
        // A missing step simply holds the state, so an interrupt can cut in.
        if (div_req.step) begin  // [RULE_05]
          if (bit_cnt_q != 5'h00) begin
            if (!trial[16]) begin
              rem_d = {trial[15:0], shifted[15:0]};
              quot_d = {quot_q[14:0], 1'b1};
            end else begin
              rem_d = shifted[31:0];
              quot_d = {quot_q[14:0], 1'b0};
            end
            bit_cnt_d = bit_cnt_q - 5'h01;
          end
          if (div_req.repeat_counter == DIV_LAST_COUNT) begin  // [RULE_04]
            state_d = DIV_DONE;
          end
        end
      end
      DIV_DONE: begin
        // Quotient to register zero, remainder to register one.
        rsp_d.valid = 1'b1;
        rsp_d.working_register_zero = neg_quot_q ? 16'(-quot_q) : quot_q;  // [RULE_06]
        rsp_d.working_register_one = neg_rem_q ? 16'(-rem_q[31:16]) : rem_q[31:16];
        busy_d = 1'b0;
        state_d = DIV_IDLE;
      end
      default: begin
        state_d = DIV_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= DIV_IDLE;
      rem_q <= 32'h0000_0000;
      quot_q <= WORD_RESET;
      dvsr_q <= WORD_RESET;
      neg_quot_q <= 1'b0;
      neg_rem_q <= 1'b0;
      bit_cnt_q <= 5'h00;
      rsp_q <= '0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      rem_q <= rem_d;
      quot_q <= quot_d;
      dvsr_q <= dvsr_d;
      neg_quot_q <= neg_quot_d;
      neg_rem_q <= neg_rem_d;
      bit_cnt_q <= bit_cnt_d;
      rsp_q <= rsp_d;
      busy_q <= busy_d;
    end
  end

  assign div_rsp = rsp_q;
  assign div_busy = busy_q;

  //////////////////////////////////////////////////////////////////////////////
  // Barrel shifter, 40 bits, one result per cycle.

  logic [39:0] operand;
  logic [39:0] shift_d, shift_q;
  logic [15:0] word_d, word_q;
  logic valid_d, valid_q;
  logic [5:0] mag;
  logic right;

  always_comb begin
    right = !shift_req.amount[5];
    mag = right ? shift_req.amount : 6'(-shift_req.amount);  // [RULE_14]
    case (shift_req.src)  // [RULE_13]
      SRC_ACC_A: operand = shift_req.acc_a;
      SRC_ACC_B: operand = shift_req.acc_b;
      SRC_XBUS: begin
        if (right) begin
          operand = {{8{shift_req.arithmetic & shift_req.xbus[15]}}, shift_req.xbus,
                     16'h0000};  // [RULE_16]
        end else begin
          operand = {24'h00_0000, shift_req.xbus};  // [RULE_16]
        end
      end
      default: operand = ACC_RESET;
    endcase
    // Limit to 16 positions; larger magnitudes saturate at 16.
    if (mag > 6'h10) begin  // [RULE_12]
      mag = 6'h10;
    end
    if (right) begin
      shift_d = shift_req.arithmetic ? 40'($signed(operand) >>> mag)
                                     : operand >> mag;  // [RULE_17]
    end else begin
      shift_d = operand << mag;  // [RULE_17]
    end
    // Word result: X bus right shifts read the X bus window, all other shifts the low word.
    word_d = (shift_req.src == SRC_XBUS && right) ? shift_d[31:16] : shift_d[15:0];  // [RULE_15]
    valid_d = shift_req.valid;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      shift_q <= ACC_RESET;
      word_q <= WORD_RESET;
      valid_q <= 1'b0;
    end else begin
      shift_q <= shift_d;  // [RULE_15]
      word_q <= word_d;
      valid_q <= valid_d;
    end
  end

  assign shift_acc_result = shift_q;
  assign shift_word_result = word_q;
  assign shift_valid = valid_q;

  //////////////////////////////////////////////////////////////////////////////
  // Data write saturation; the accumulator itself is never written here.

  logic [15:0] sat_d, sat_q;
  logic sat_valid_d, sat_valid_q;
  logic over_pos, over_neg;

  always_comb begin
    // Sign comes from accumulator bit 39, so an overflowed value clamps the right way.
    over_pos = !sat_req.acc_sign &&
               ((sat_req.rounded > SAT_POS_LIMIT) || sat_req.acc_overflow ||
                sat_req.round_overflow);  // [RULE_10]
    over_neg = sat_req.acc_sign &&
               ((sat_req.rounded < SAT_NEG_LIMIT) || sat_req.acc_overflow);  // [RULE_10]
    if (!sat_req.data_write_saturation_enable) begin
      sat_d = sat_req.rounded[15:0];  // [RULE_11]
    end else if (over_pos) begin
      sat_d = SAT_POS_WORD;  // [RULE_08]
    end else if (over_neg) begin
      sat_d = SAT_NEG_WORD;  // [RULE_09]
    end else begin
      sat_d = sat_req.rounded[15:0];  // [RULE_07]
    end
    sat_valid_d = sat_req.valid;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sat_q <= WORD_RESET;
      sat_valid_q <= 1'b0;
    end else begin
      sat_q <= sat_d;
      sat_valid_q <= sat_valid_d;
    end
  end

  assign sat_word = sat_q;
  assign sat_valid = sat_valid_q;

endmodule

// File: testbench/dsp_arith_datapath_chk.sv
module dsp_arith_datapath_chk
  import dsp_arith_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input div_req_s div_req,
  input div_rsp_s div_rsp,
  input wire logic div_busy,
  input shift_req_s shift_req,
  input wire logic [39:0] shift_acc_result,
  input wire logic [15:0] shift_word_result,
  input wire logic shift_valid,
  input sat_req_s sat_req,
  input wire logic [15:0] sat_word,
  input wire logic sat_valid
);
  timeunit 1ns;
  timeprecision 1ns;

  // One clock domain, so reset masks every check.
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Short names for the qualified requests.
  wire logic sat_en = sat_req.valid && sat_req.data_write_saturation_enable;
  wire logic sh_a = shift_req.valid && shift_req.src == SRC_ACC_A;
  wire logic step = div_req.step;

  //////////////////////////////////////////////////////////////////////////
  AST_SAT_HIGH:
    assert property (sat_en && !sat_req.acc_sign && sat_req.rounded > SAT_POS_LIMIT
      |=> sat_word == SAT_POS_WORD) else $error("high clamp missing");
  AST_SAT_LOW:
    assert property (sat_en && sat_req.acc_sign && sat_req.rounded < SAT_NEG_LIMIT
      |=> sat_word == SAT_NEG_WORD) else $error("low clamp missing");
  AST_SAT_PASS:
    assert property (sat_req.valid && !sat_req.data_write_saturation_enable
      |=> sat_word == $past(sat_req.rounded[15:0])) else $error("pass value changed");
  AST_SHIFT_ZERO:
    assert property (sh_a && shift_req.amount == 6'h00
      |=> shift_acc_result == $past(shift_req.acc_a)) else $error("zero shift moved");
  AST_SHIFT_ARITH:
    assert property (sh_a && shift_req.arithmetic && shift_req.amount == 6'h04
      |=> shift_acc_result == {{4{$past(shift_req.acc_a[39])}}, $past(shift_req.acc_a[39:4])})
      else $error("sign fill wrong");
  AST_SHIFT_LEFT:
    assert property (shift_req.valid && shift_req.src == SRC_ACC_B && shift_req.amount == 6'h3C
      |=> shift_acc_result == {$past(shift_req.acc_b[35:0]), 4'h0}) else $error("left shift wrong");
  AST_SHIFT_VALID:
    assert property (shift_req.valid |=> shift_valid) else $error("shift result late");
  AST_DIV_START:
    assert property (step && div_req.repeat_counter == 6'h11 && !div_busy |=> div_busy)
      else $error("divide did not start");
  AST_DIV_IGNORE:
    assert property (step && div_req.repeat_counter != 6'h11 && !div_busy |=> !div_busy)
      else $error("stray step started a divide");
  AST_DIV_END:
    assert property (step && div_req.repeat_counter == 6'h00 && div_busy
      |-> ##[1:3] div_rsp.valid) else $error("divide result late");
  AST_DIV_PULSE:
    assert property (div_rsp.valid |=> !div_rsp.valid) else $error("result not a pulse");

  // Main scenarios seen at least once.
  cover property (div_rsp.valid);
  cover property (sat_en && !sat_req.acc_sign && sat_req.rounded > SAT_POS_LIMIT);
  cover property (shift_req.valid && shift_req.src == SRC_XBUS);
endmodule

// File: testbench/div_ctrl_model.sv
module div_ctrl_model
  import dsp_arith_pkg::*;
(
  input wire logic clk,
  output div_req_s div_req
);
  timeunit 1ns;
  timeprecision 1ns;

  // Quiet until the bench asks for a divide.
  initial div_req = '0;

  // A repeat loop issues the step once per count, 17 down to 0, which is 18
  // steps; the divider never loads the count itself.
  // The slow form pauses mid-loop as an interrupt would.
  task automatic run(input divide_op_e op, input logic [15:0] lo, input logic [15:0] hi,
    input logic [15:0] d, input logic slow);
    div_req.op = op;
    div_req.dividend_lo = lo;
    div_req.dividend_hi = hi;
    div_req.divisor = d;
    for (int c = 17; c >= 0; c--) begin
      if (slow && c == 9) begin
        div_req.step = 1'b0;
        repeat (3) @(negedge clk);
      end
      div_req.step = 1'b1;
      div_req.repeat_counter = c[5:0];
      @(negedge clk);
    end
    // The released dividend low word and divisor no longer hold their old value.
    div_req.step = 1'b0;
    div_req.dividend_lo = ~lo;
    div_req.divisor = ~d;
  endtask
endmodule

// File: testbench/dsp_arith_datapath_tb.sv
module dsp_arith_datapath_tb
  import dsp_arith_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    shift_src_e src;
    logic ar;
    logic [5:0] amt;
    logic [39:0] ea;
    logic [15:0] ew;
    logic en;
    logic [23:0] rnd;
    logic sg;
    logic ov;
    logic [15:0] es;
  } row_s;

  localparam logic [39:0] ACC0 = 40'h80_1234_5678;
  localparam logic [15:0] XW = 16'h8421;

  logic clk = 1'b0;
  logic rst = 1'b1;
  div_req_s div_req;
  div_rsp_s div_rsp;
  logic div_busy;
  shift_req_s shift_req = '0;
  logic [39:0] shift_acc_result;
  logic [15:0] shift_word_result;
  logic shift_valid;
  sat_req_s sat_req = '0;
  logic [15:0] sat_word;
  logic sat_valid;
  int failures = 0;
  int samples_checked = 0;
  row_s r;

  // Shift and saturation cases side by side; expected values worked by hand.
  row_s rows [8] = '{
    '{SRC_ACC_A, 1'b0, 6'h00, ACC0, '0, 1'b1, 24'h00_8000, 1'b0, 1'b0, 16'h7FFF},
    '{SRC_ACC_A, 1'b1, 6'h04, 40'hF8_0123_4567, '0, 1'b1, 24'hFF_7FFF, 1'b1, 1'b0, 16'h8000},
    '{SRC_ACC_A, 1'b0, 6'h10, 40'h00_0080_1234, '0, 1'b0, 24'h00_8000, 1'b0, 1'b0, 16'h8000},
    '{SRC_ACC_B, 1'b0, 6'h3C, 40'h01_2345_6780, '0, 1'b1, 24'h00_1234, 1'b0, 1'b0, 16'h1234},
    '{SRC_XBUS, 1'b0, 6'h04, '0, 16'h0842, 1'b1, 24'hFF_8000, 1'b1, 1'b0, 16'h8000},
    '{SRC_XBUS, 1'b0, 6'h3C, '0, 16'h4210, 1'b1, 24'h00_7FFF, 1'b0, 1'b0, 16'h7FFF},
    '{SRC_XBUS, 1'b1, 6'h04, '0, 16'hF842, 1'b0, 24'hFF_7FFF, 1'b1, 1'b0, 16'h7FFF},
    '{SRC_ACC_A, 1'b0, 6'h30, 40'h34_5678_0000, '0, 1'b1, 24'h00_0001, 1'b0, 1'b1, 16'h7FFF}
  };

  // A 50 ns core clock.
  always #25 clk = ~clk;

  dsp_arith_datapath i_dsp_arith_datapath (.clk(clk), .rst(rst), .div_req(div_req),
    .div_rsp(div_rsp), .div_busy(div_busy), .shift_req(shift_req),
    .shift_acc_result(shift_acc_result), .shift_word_result(shift_word_result),
    .shift_valid(shift_valid), .sat_req(sat_req), .sat_word(sat_word), .sat_valid(sat_valid));

  div_ctrl_model i_div_ctrl_model (.clk(clk), .div_req(div_req));

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checked %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Reference quotient and remainder; signed forms truncate toward zero.
  function automatic logic [31:0] div_exp(input divide_op_e op, input logic [15:0] lo,
    input logic [15:0] hi, input logic [15:0] d);
    longint n;
    longint m;
    longint q;
    longint s;
    m = $signed(d);
    case (op)
      OP_FRACTIONAL_DIVIDE: n = $signed({lo, 16'h0000});
      OP_SIGNED_LONG_DIVIDE: n = $signed({hi, lo});
      OP_UNSIGNED_LONG_DIVIDE: begin n = {hi, lo}; m = d; end
      OP_SIGNED_SHORT_DIVIDE: n = $signed(lo);
      default: begin n = lo; m = d; end
    endcase
    q = n / m;
    s = n % m;
    return {q[15:0], s[15:0]};
  endfunction

  // Runs one divide through the controller model and checks the answer.
  task automatic do_div(input divide_op_e op, input logic [15:0] lo, input logic [15:0] hi,
    input logic [15:0] d, input logic slow);
    int n;
    i_div_ctrl_model.run(op, lo, hi, d, slow);
    for (n = 0; n < 4 && div_rsp.valid !== 1'b1; n++) @(negedge clk);
    check(div_rsp.valid, 1'b1);
    check(div_busy, 1'b0);
    check({div_rsp.working_register_zero, div_rsp.working_register_one},
      div_exp(op, lo, hi, d));
    @(negedge clk);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, table of cases back to back, then the divides.
  initial begin
    repeat (3) @(negedge clk);
    // Split so that no compare is wider than the 40-bit check arguments.
    check(div_busy, 1'b0);
    check(div_rsp, '0);
    check({shift_valid, sat_valid, sat_word}, '0);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      r = rows[i];
      shift_req = '{1'b1, r.src, r.ar, r.amt, (r.src == SRC_ACC_B) ? ~ACC0 : ACC0,
        (r.src == SRC_ACC_B) ? ACC0 : ~ACC0, XW};
      sat_req = '{1'b1, r.en, r.rnd, r.sg, r.ov, 1'b0};
      @(negedge clk);
      if (r.src == SRC_XBUS) check(shift_word_result, r.ew);
      else check(shift_acc_result, r.ea);
      check({shift_valid, sat_valid, sat_word}, {2'b11, r.es});
    end
    shift_req = '0;
    sat_req = '0;
    // Every divide kind; short forms get junk in the upper half.
    do_div(OP_FRACTIONAL_DIVIDE, 16'hF000, 16'h5555, 16'h4000, 1'b0);
    do_div(OP_SIGNED_LONG_DIVIDE, 16'h0001, 16'hFFFE, 16'h0100, 1'b0);
    do_div(OP_UNSIGNED_LONG_DIVIDE, 16'h3456, 16'h0012, 16'h0100, 1'b0);
    do_div(OP_SIGNED_SHORT_DIVIDE, 16'h8001, 16'hFFFF, 16'h0010, 1'b0);
    do_div(OP_UNSIGNED_SHORT_DIVIDE, 16'h8001, 16'hFFFF, 16'h0010, 1'b0);
    do_div(OP_UNSIGNED_LONG_DIVIDE, 16'h3456, 16'h0012, 16'h0100, 1'b1);
    // Reset mid-divide: the remaining steps are not a fresh start.
    fork
      i_div_ctrl_model.run(OP_UNSIGNED_SHORT_DIVIDE, 16'h8001, 16'h0000, 16'h0010, 1'b0);
      begin
        repeat (5) @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
      end
    join
    repeat (3) begin
      check({div_busy, div_rsp.valid}, 2'b00);
      @(negedge clk);
    end
    finish_test();
  end

  // Cuts a hang well past the expected 155 or so cycles.
  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    finish_test();
  end
endmodule

bind dsp_arith_datapath dsp_arith_datapath_chk i_dsp_arith_datapath_chk (.clk(clk), .rst(rst),
  .div_req(div_req), .div_rsp(div_rsp), .div_busy(div_busy), .shift_req(shift_req),
  .shift_acc_result(shift_acc_result), .shift_word_result(shift_word_result),
  .shift_valid(shift_valid), .sat_req(sat_req), .sat_word(sat_word), .sat_valid(sat_valid));
